// File: design/byte_alu_params.svh
// offsets, field positions, reset values and widths of the byte alu register map
`ifndef BYTE_ALU_PARAMS_SVH
`define BYTE_ALU_PARAMS_SVH
`define OFF_CMD 8'h00
`define OFF_ACC 8'h04
`define OFF_STATUS 8'h08
`define OFF_RESULT 8'h0C
`define OFF_DIR_A 8'h10
`define OFF_DIR_B 8'h14
`define OFF_DIR_C 8'h18
`define OFF_FILE_ADDR 8'h1C
`define OFF_FILE_DATA 8'h20
`define CMD_OP_LSB 0
`define CMD_OP_MSB 2
`define CMD_DEST_BIT 4
`define CMD_DEST_GIVEN_BIT 5
`define CMD_LIT_LSB 8
`define CMD_LIT_MSB 15
`define CMD_FADDR_LSB 16
`define CMD_FADDR_MSB 22
`define ST_C 0
`define ST_DC 1
`define ST_Z 2
`define ST_ERR 3
`define DIR_SEL_A 7'h05
`define DIR_SEL_B 7'h06
`define DIR_SEL_C 7'h07
`define DEST_ACC 1'b0
`define DEST_FILE 1'b1
`define ACC_RESET 8'h00
`define DIR_RESET 8'hFF
`define FILE_RESET 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: design/byte_alu_pkg.sv
// types shared by the byte alu files
package byte_alu_pkg;
   typedef enum logic [2:0] {
      OP_SUB_ACC_FROM_REG = 3'b000,
      OP_SUB_WITH_BORROW = 3'b001,
      OP_NIBBLE_EXCHANGE = 3'b010,
      OP_DIRECTION_LOAD = 3'b011,
      OP_XOR_LITERAL = 3'b100,
      OP_XOR_REGISTER = 3'b101
   } op_e;
endpackage

// File: design/file_reg_bank.sv
// flip-flop file register bank, one write port and two read ports
`timescale 1ns/100ps
`include "byte_alu_params.svh"
module file_reg_bank #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 128,
   parameter int AW = 7
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic [AW-1:0] raddr_a,
   output logic [WIDTH-1:0] rdata_a,
   input wire logic [AW-1:0] raddr_b,
   output logic [WIDTH-1:0] rdata_b
);
   logic [WIDTH-1:0] mem_reg [DEPTH];

   // storage cleared at reset so reads are never unknown
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_reg[i] <= `FILE_RESET;
         end
      end else if (we) begin
         mem_reg[waddr] <= wdata;
      end
   end

   // both read ports are combinational
   assign rdata_a = mem_reg[raddr_a];
   assign rdata_b = mem_reg[raddr_b];
endmodule

// File: design/byte_alu.sv
// byte alu datapath for subtract, swap, direction load and xor, with axi4-lite register access
// Summary of operation
// - subtract acc from reg; carry, half-carry, zero compare
// - borrow subtract: reg minus acc minus borrow
// - borrow subtract destination: 0 acc, 1 register
// - nibble exchange swaps halves, flags unchanged
// - nibble exchange destination, register by default
// - direction load copies acc, operand 5-7
// - literal xor into acc, zero only
// - register xor to chosen destination, zero only
`timescale 1ns/100ps
`include "byte_alu_params.svh"
module byte_alu #(
   parameter int ADDR_W = 8,
   parameter int FILE_DEPTH = 128,
   parameter int FILE_AW = 7
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [7:0] port_a_direction,
   output logic [7:0] port_b_direction,
   output logic [7:0] port_c_direction
);
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rdata_reg;
   logic [ADDR_W-1:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic [7:0] acc_reg;
   logic carry_reg;
   logic half_carry_flag_reg;
   logic zero_reg;
   logic err_reg;
   logic [7:0] result_reg;
   logic [7:0] dir_a_reg;
   logic [7:0] dir_b_reg;
   logic [7:0] dir_c_reg;
   logic [FILE_AW-1:0] file_addr_reg;
   logic do_write;
   logic wr_known;
   logic cmd_exec;
   logic bus_file_we;
   logic [7:0] file_val;
   logic [7:0] bus_file_val;
   byte_alu_pkg::op_e op;
   logic [FILE_AW-1:0] faddr;
   logic [7:0] literal;
   logic dest_sel;
   logic [8:0] sum_full;
   logic [4:0] sum_low;
   logic carry_in;
   logic [7:0] res_next;
   logic wr_acc;
   logic wr_file;
   logic upd_c;
   logic upd_dc;
   logic upd_z;
   logic ld_dir_a;
   logic ld_dir_b;
   logic ld_dir_c;
   logic bad_cmd;
   logic file_we;
   logic [FILE_AW-1:0] file_waddr;
   logic [7:0] file_wdata;

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;
   assign port_a_direction = dir_a_reg;
   assign port_b_direction = dir_b_reg;
   assign port_c_direction = dir_c_reg;

   // write commits once address and data are both held and no response is pending
   assign do_write = !awready_reg && !wready_reg && !bvalid_reg;
   assign cmd_exec = do_write && (awaddr_reg == `OFF_CMD) && (wstrb_reg != 4'h0);

   // command fields decoded from the held write data
   assign op = byte_alu_pkg::op_e'(wdata_reg[`CMD_OP_MSB:`CMD_OP_LSB]);
   assign faddr = wdata_reg[`CMD_FADDR_MSB:`CMD_FADDR_LSB];
   assign literal = wdata_reg[`CMD_LIT_MSB:`CMD_LIT_LSB];
   // an omitted destination means the file register
   assign dest_sel = wdata_reg[`CMD_DEST_GIVEN_BIT] ? wdata_reg[`CMD_DEST_BIT] : `DEST_FILE;

   // register minus acc as register plus inverted acc plus carry-in; carry-out is no-borrow
   assign carry_in = (op == byte_alu_pkg::OP_SUB_WITH_BORROW) ? carry_reg : 1'b1;
   assign sum_full = {1'b0, file_val} + {1'b0, ~acc_reg} + {8'h00, carry_in};
   assign sum_low = {1'b0, file_val[3:0]} + {1'b0, ~acc_reg[3:0]} + {4'h0, carry_in};

   // operation decode: result, destination and which flags move
   always_comb begin
      res_next = 8'h00;
      wr_acc = 1'b0;
      wr_file = 1'b0;
      upd_c = 1'b0;
      upd_dc = 1'b0;
      upd_z = 1'b0;
      ld_dir_a = 1'b0;
      ld_dir_b = 1'b0;
      ld_dir_c = 1'b0;
      bad_cmd = 1'b0;
      case (op)
         byte_alu_pkg::OP_SUB_ACC_FROM_REG, byte_alu_pkg::OP_SUB_WITH_BORROW: begin
            res_next = sum_full[7:0];
            wr_acc = (dest_sel == `DEST_ACC);
            wr_file = (dest_sel == `DEST_FILE);
            upd_c = 1'b1;
            upd_dc = 1'b1;
            upd_z = 1'b1;
         end
         byte_alu_pkg::OP_NIBBLE_EXCHANGE: begin
            res_next = {file_val[3:0], file_val[7:4]};
            wr_acc = (dest_sel == `DEST_ACC);
            wr_file = (dest_sel == `DEST_FILE);
         end
         byte_alu_pkg::OP_DIRECTION_LOAD: begin
            res_next = acc_reg;
            ld_dir_a = (faddr == `DIR_SEL_A);
            ld_dir_b = (faddr == `DIR_SEL_B);
            ld_dir_c = (faddr == `DIR_SEL_C);
            bad_cmd = !(ld_dir_a || ld_dir_b || ld_dir_c);
         end
         byte_alu_pkg::OP_XOR_LITERAL: begin
            res_next = acc_reg ^ literal;
            wr_acc = 1'b1;
            upd_z = 1'b1;
         end
         byte_alu_pkg::OP_XOR_REGISTER: begin
            res_next = acc_reg ^ file_val;
            wr_acc = (dest_sel == `DEST_ACC);
            wr_file = (dest_sel == `DEST_FILE);
            upd_z = 1'b1;
         end
         default: begin
            bad_cmd = 1'b1;
         end
      endcase
   end

   // known offsets; anything else answers slverr
   always_comb begin
      if (awaddr_reg == `OFF_CMD) begin
         wr_known = 1'b1;
      end else if (awaddr_reg == `OFF_ACC || awaddr_reg == `OFF_STATUS) begin
         wr_known = 1'b1;
      end else if (awaddr_reg == `OFF_FILE_ADDR || awaddr_reg == `OFF_FILE_DATA) begin
         wr_known = 1'b1;
      end else if (awaddr_reg == `OFF_RESULT || awaddr_reg == `OFF_DIR_A) begin
         wr_known = 1'b1;
      end else if (awaddr_reg == `OFF_DIR_B || awaddr_reg == `OFF_DIR_C) begin
         wr_known = 1'b1;
      end else begin
         wr_known = 1'b0;
      end
   end

   // file bank: command write-back and bus access never coincide, one write commits per response
   assign bus_file_we = do_write && (awaddr_reg == `OFF_FILE_DATA) && wstrb_reg[0];
   assign file_we = (cmd_exec && wr_file) || bus_file_we;
   assign file_waddr = cmd_exec ? faddr : file_addr_reg;
   assign file_wdata = cmd_exec ? res_next : wdata_reg[7:0];

   file_reg_bank #(
      .WIDTH(8),
      .DEPTH(FILE_DEPTH),
      .AW(FILE_AW)
   ) u_bank (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .we(file_we),
      .waddr(file_waddr),
      .wdata(file_wdata),
      .raddr_a(faddr),
      .rdata_a(file_val),
      .raddr_b(file_addr_reg),
      .rdata_b(bus_file_val)
   );

   // write address and data channels, taken in either order
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         awaddr_reg <= '0;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
      end else begin
         if (awready_reg && s_axi_awvalid) begin
            awready_reg <= 1'b0;
            awaddr_reg <= s_axi_awaddr;
         end else if (bvalid_reg && s_axi_bready) begin
            awready_reg <= 1'b1;
         end
         if (wready_reg && s_axi_wvalid) begin
            wready_reg <= 1'b0;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end else if (bvalid_reg && s_axi_bready) begin
            wready_reg <= 1'b1;
         end
      end
   end

   // write response held until the master takes it
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= `RESP_OKAY;
      end else if (do_write) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // accumulator: loaded by software or by an operation aimed at it
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         acc_reg <= `ACC_RESET;
      end else if (cmd_exec && wr_acc) begin
         acc_reg <= res_next;
      end else if (do_write && awaddr_reg == `OFF_ACC && wstrb_reg[0]) begin
         acc_reg <= wdata_reg[7:0];
      end
   end

   // status flags; swap leaves them alone, direction load only sets the error bit on an operand outside 5-7
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         carry_reg <= 1'b0;
         half_carry_flag_reg <= 1'b0;
         zero_reg <= 1'b0;
         err_reg <= 1'b0;
         result_reg <= 8'h00;
      end else if (cmd_exec) begin
         result_reg <= res_next;
         if (upd_c) begin
            carry_reg <= sum_full[8];
         end
         if (upd_dc) begin
            half_carry_flag_reg <= sum_low[4];
         end
         if (upd_z) begin
            zero_reg <= (res_next == 8'h00);
         end
         err_reg <= err_reg || bad_cmd;
      end else if (do_write && awaddr_reg == `OFF_STATUS && wstrb_reg[0]) begin
         carry_reg <= wdata_reg[`ST_C];
         half_carry_flag_reg <= wdata_reg[`ST_DC];
         zero_reg <= wdata_reg[`ST_Z];
         // error bit is write-one-to-clear so flag loads do not wipe it
         err_reg <= err_reg && !wdata_reg[`ST_ERR];
      end
   end

   // direction registers, reset to all inputs
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         dir_a_reg <= `DIR_RESET;
         dir_b_reg <= `DIR_RESET;
         dir_c_reg <= `DIR_RESET;
      end else if (cmd_exec) begin
         if (ld_dir_a) begin
            dir_a_reg <= acc_reg;
         end
         if (ld_dir_b) begin
            dir_b_reg <= acc_reg;
         end
         if (ld_dir_c) begin
            dir_c_reg <= acc_reg;
         end
      end
   end

   // pointer for bus access to the file bank
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         file_addr_reg <= '0;
      end else if (do_write && awaddr_reg == `OFF_FILE_ADDR && wstrb_reg[0]) begin
         file_addr_reg <= wdata_reg[FILE_AW-1:0];
      end
   end

   // read channel: one cycle to answer, data held until taken
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rresp_reg <= `RESP_OKAY;
         rdata_reg <= 32'h00000000;
      end else if (arready_reg && s_axi_arvalid) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rresp_reg <= `RESP_OKAY;
         if (s_axi_araddr == `OFF_CMD) begin
            rdata_reg <= 32'h00000000;
         end else if (s_axi_araddr == `OFF_ACC) begin
            rdata_reg <= {24'h000000, acc_reg};
         end else if (s_axi_araddr == `OFF_STATUS) begin
            rdata_reg <= {28'h0000000, err_reg, zero_reg, half_carry_flag_reg, carry_reg};
         end else if (s_axi_araddr == `OFF_RESULT) begin
            rdata_reg <= {24'h000000, result_reg};
         end else if (s_axi_araddr == `OFF_DIR_A) begin
            rdata_reg <= {24'h000000, dir_a_reg};
         end else if (s_axi_araddr == `OFF_DIR_B) begin
            rdata_reg <= {24'h000000, dir_b_reg};
         end else if (s_axi_araddr == `OFF_DIR_C) begin
            rdata_reg <= {24'h000000, dir_c_reg};
         end else if (s_axi_araddr == `OFF_FILE_ADDR) begin
            rdata_reg <= {{(32 - FILE_AW){1'b0}}, file_addr_reg};
         end else if (s_axi_araddr == `OFF_FILE_DATA) begin
            rdata_reg <= {24'h000000, bus_file_val};
         end else begin
            rdata_reg <= 32'h00000000;
            rresp_reg <= `RESP_SLVERR;
         end
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_reg <= 1'b0;
         arready_reg <= 1'b1;
      end
   end
endmodule

// File: sim/byte_alu_chk.sv
// assertion checker for the byte alu bus handshakes and direction outputs
`timescale 1ns/100ps
module byte_alu_chk (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] port_a_direction,
   input wire logic [7:0] port_b_direction,
   input wire logic [7:0] port_c_direction
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   logic [23:0] dirs;
   // all three directions in one word for change tracking
   assign dirs = {port_a_direction, port_b_direction, port_c_direction};
   // commit lands one edge after both halves, so the response is seen at the edge after that
   a_b_after_hs: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("write response late");
   a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   a_w_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_resp_legal: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
      else $error("bad write response code");
   // directions only move at a command commit, one port at a time
   a_dir_commit: assert property ($changed(dirs) |-> $rose(s_axi_bvalid))
      else $error("direction changed outside commit");
   a_dir_single: assert property ($onehot0({$changed(port_a_direction),
      $changed(port_b_direction), $changed(port_c_direction)})) else $error("two directions changed");
   cp_b_stall: cover property (s_axi_bvalid && !s_axi_bready);
   cp_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
   cp_dir: cover property ($changed(dirs));
endmodule
bind byte_alu byte_alu_chk i_chk (.clk_sys, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .port_a_direction, .port_b_direction, .port_c_direction);

// File: sim/tb_byte_alu.sv
// self-checking bench for the byte alu through its register bus
`timescale 1ns/100ps
`include "byte_alu_params.svh"
module tb_byte_alu;
   typedef struct packed {
      logic [2:0] op; logic d; logic dg; logic [6:0] fa;
      logic [7:0] acc, fv, lit, ea, ef; logic [2:0] si, es;
   } row_s;
   logic clk_sys, nrst;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] port_a_direction, port_b_direction, port_c_direction;
   logic [7:0] dexp [3];
   int n_errors = 0;
   int check_count = 0;
   int cyc = 0;
   row_s rows [14];
   byte_alu i_byte_alu (.*);
   initial begin
      clk_sys = 0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic print_verdict;
      if (n_errors == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // hang guard, far above the few hundred cycles the run needs
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         print_verdict();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // bready held low one cycle after bvalid so every write sees a stall
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `RESP_OKAY);
      logic aw;
      logic w;
      aw = 1;
      w = 1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      while (aw || w) begin
         @(posedge clk_sys);
         if (aw && s_axi_awready) begin
            aw = 0;
            s_axi_awvalid <= 0;
         end
         if (w && s_axi_wready) begin
            w = 0;
            s_axi_wvalid <= 0;
         end
      end
      repeat (2) @(posedge clk_sys);
      s_axi_bready <= 1;
      do @(posedge clk_sys); while (!s_axi_bvalid);
      s_axi_bready <= 0;
      chk({30'h0, s_axi_bresp}, {30'h0, er});
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = `RESP_OKAY);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      do @(posedge clk_sys); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      @(posedge clk_sys);
      s_axi_rready <= 1;
      do @(posedge clk_sys); while (!s_axi_rvalid);
      s_axi_rready <= 0;
      chk(s_axi_rdata, e);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
   endtask
   task automatic dirchk;
      chk({8'h0, port_a_direction, port_b_direction, port_c_direction}, {8'h0, dexp[0], dexp[1], dexp[2]});
   endtask
   initial begin
      // op, dest, dest given, address, acc, file, literal, acc after, file after, flags in, flags out
      rows = '{'{3'h0, 1'b0, 1'b1, 7'h00, 8'h05, 8'h05, 8'h00, 8'h00, 8'h05, 3'h0, 3'h7},
         '{3'h0, 1'b1, 1'b1, 7'h7F, 8'h16, 8'h25, 8'h00, 8'h16, 8'h0F, 3'h0, 3'h1},
         '{3'h0, 1'b0, 1'b1, 7'h10, 8'h30, 8'h20, 8'h00, 8'hF0, 8'h20, 3'h0, 3'h2},
         '{3'h1, 1'b1, 1'b1, 7'h20, 8'h10, 8'h30, 8'h00, 8'h10, 8'h1F, 3'h0, 3'h1},
         '{3'h1, 1'b0, 1'b1, 7'h30, 8'h10, 8'h10, 8'h00, 8'h00, 8'h10, 3'h1, 3'h7},
         '{3'h2, 1'b0, 1'b1, 7'h40, 8'h3C, 8'hA5, 8'h00, 8'h5A, 8'hA5, 3'h5, 3'h5},
         '{3'h2, 1'b0, 1'b0, 7'h41, 8'h3C, 8'h12, 8'h00, 8'h3C, 8'h21, 3'h2, 3'h2},
         '{3'h4, 1'b0, 1'b1, 7'h42, 8'h0F, 8'h77, 8'hF0, 8'hFF, 8'h77, 3'h3, 3'h3},
         '{3'h4, 1'b1, 1'b1, 7'h43, 8'hA5, 8'h66, 8'hA5, 8'h00, 8'h66, 3'h0, 3'h4},
         '{3'h5, 1'b1, 1'b1, 7'h7F, 8'h33, 8'h0F, 8'h00, 8'h33, 8'h3C, 3'h7, 3'h3},
         '{3'h5, 1'b0, 1'b1, 7'h01, 8'h44, 8'h44, 8'h00, 8'h00, 8'h44, 3'h0, 3'h4},
         '{3'h3, 1'b0, 1'b1, 7'h05, 8'h81, 8'h11, 8'h00, 8'h81, 8'h11, 3'h6, 3'h6},
         '{3'h3, 1'b0, 1'b1, 7'h06, 8'h42, 8'h22, 8'h00, 8'h42, 8'h22, 3'h6, 3'h6},
         '{3'h3, 1'b0, 1'b1, 7'h07, 8'h00, 8'h33, 8'h00, 8'h00, 8'h33, 3'h6, 3'h6}};
      dexp = '{default: 8'hFF};
      nrst = 0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      repeat (20) @(posedge clk_sys);
      nrst <= 1;
      @(posedge clk_sys);
      dirchk();
      rdc(`OFF_ACC, 32'h0);
      for (int i = 0; i < 14; i++) begin
         wr(`OFF_ACC, {24'h0, rows[i].acc});
         wr(`OFF_FILE_ADDR, {25'h0, rows[i].fa});
         wr(`OFF_FILE_DATA, {24'h0, rows[i].fv});
         wr(`OFF_STATUS, {29'h1, rows[i].si});
         wr(`OFF_CMD, {9'h0, rows[i].fa, rows[i].lit, 2'h0, rows[i].dg, rows[i].d, 1'b0, rows[i].op});
         if (rows[i].op == byte_alu_pkg::OP_DIRECTION_LOAD) dexp[rows[i].fa - 7'h05] = rows[i].acc;
         rdc(`OFF_ACC, {24'h0, rows[i].ea});
         rdc(`OFF_FILE_DATA, {24'h0, rows[i].ef});
         rdc(`OFF_STATUS, {29'h0, rows[i].es});
         dirchk();
      end
      // unmapped place answers with an error and holds nothing
      wr(8'h40, 32'h0000_00AA, `RESP_SLVERR);
      rdc(8'h40, 32'h0, `RESP_SLVERR);
      // direction registers are read-only from the bus
      wr(`OFF_DIR_A, 32'h0);
      rdc(`OFF_DIR_A, {24'h0, dexp[0]});
      // operand 4 is outside the port range: no load, error raised
      wr(`OFF_ACC, 32'h5A);
      wr(`OFF_STATUS, 32'h8);
      wr(`OFF_CMD, {9'h0, 7'h04, 8'h0, 8'h13});
      dirchk();
      rdc(`OFF_STATUS, 32'h8);
      wr(`OFF_STATUS, 32'h8);
      rdc(`OFF_STATUS, 32'h0);
      // last result is the loaded accumulator; command reads zero; pointer keeps its last value
      rdc(`OFF_RESULT, 32'h5A);
      rdc(`OFF_CMD, 32'h0);
      rdc(`OFF_FILE_ADDR, 32'h07);
      // unknown opcode raises the error bit and clears the result; the accumulator is kept
      wr(`OFF_CMD, 32'h6);
      rdc(`OFF_STATUS, 32'h8);
      rdc(`OFF_ACC, 32'h5A);
      // byte lane 0 off leaves the accumulator alone
      s_axi_wstrb <= 4'hE;
      wr(`OFF_ACC, 32'hFF);
      s_axi_wstrb <= 4'hF;
      rdc(`OFF_ACC, 32'h5A);
      // reset in mid-run restores the direction and accumulator values
      nrst <= 0;
      repeat (2) @(posedge clk_sys);
      nrst <= 1;
      @(posedge clk_sys);
      dexp = '{default: 8'hFF};
      dirchk();
      rdc(`OFF_ACC, 32'h0);
      rdc(`OFF_STATUS, 32'h0);
      rdc(`OFF_FILE_DATA, 32'h0);
      print_verdict();
   end
endmodule
